/* File: hw/cic_defs.svh */
// Constants of the core interrupt controller: widths, table layout, trap vectors and levels.
`ifndef CIC_DEFS_SVH
`define CIC_DEFS_SVH

`define CIC_NUM_IRQ       246
`define CIC_VEC_W         8
`define CIC_LVL_W         4
`define CIC_PRIO_W        3
`define CIC_ADDR_W        24
`define CIC_WORD_W        16
`define CIC_IDX_W         6
`define CIC_CNT_W         3
`define CIC_FLAGS_PER_REG 16
`define CIC_PRIO_PER_REG  4
`define CIC_PRIO_STRIDE   4

`define CIC_TABLE_BASE    24'h00_0004
`define CIC_TABLE_SPAN    24'h00_0200
`define CIC_RESET_PC      24'h00_0000
`define CIC_IRQ_VEC_OFS   8'h08

`define CIC_VEC_OSC       8'h00
`define CIC_VEC_ADDR      8'h01
`define CIC_VEC_HARD      8'h02
`define CIC_VEC_STACK     8'h03
`define CIC_VEC_MATH      8'h04
`define CIC_VEC_SOFT      8'h06

`define CIC_LVL_OSC       4'hf
`define CIC_LVL_ADDR      4'he
`define CIC_LVL_HARD      4'hd
`define CIC_LVL_STACK     4'hc
`define CIC_LVL_MATH      4'hb
`define CIC_LVL_SOFT      4'h9
`define CIC_LVL_USER_MAX  4'h7

`define CIC_RET_PRELOAD   3'h1

`endif

/* File: hw/cic_pkg.sv */
// Types and shared decoding functions of the core interrupt controller.
`include "cic_defs.svh"
package cic_pkg;

  typedef enum logic [1:0] {
    CIC_KIND_FLAG   = 2'b00,
    CIC_KIND_ENABLE = 2'b01,
    CIC_KIND_PRIO   = 2'b10
  } cic_kind_e;

  typedef enum logic [2:0] {
    ST_IDLE  = 3'b000,
    ST_FETCH = 3'b001,
    ST_WAIT  = 3'b010,
    ST_ENTRY = 3'b011,
    ST_RET   = 3'b100
  } cic_state_e;

  typedef struct packed {
    logic osc_fail;
    logic address_error;
    logic stack_error;
    logic double_bit_mem_error;
    logic software_hard_trap;
    logic acc_a_overflow;
    logic acc_b_overflow;
    logic acc_a_catastrophic;
    logic acc_b_catastrophic;
    logic shift_acc_error;
    logic divide_by_zero;
    logic bus_error_one;
    logic no_address_error;
    logic data_address_error;
    logic bus_error_two;
    logic loop_nesting_overflow;
    logic auxiliary_pll_unlock;
  } cic_trap_s;

  typedef struct packed {
    logic software_hard_trap_en;
    logic acc_a_ovf_en;
    logic acc_b_ovf_en;
    logic catastrophic_en;
  } cic_trap_en_s;

  typedef struct packed {
    logic                   flag;
    logic                   enable;
    logic [`CIC_PRIO_W-1:0] prio;
  } cic_slot_s;

  typedef struct packed {
    logic                   valid;
    cic_kind_e              kind;
    logic [`CIC_IDX_W-1:0]  index;
    logic [`CIC_WORD_W-1:0] data;
  } cic_wr_s;

  typedef struct packed {
    cic_kind_e             kind;
    logic [`CIC_IDX_W-1:0] index;
  } cic_rd_s;

  typedef struct packed {
    cic_state_e             state;
    logic [`CIC_CNT_W-1:0]  cnt;
    logic                   pend;
    logic [`CIC_VEC_W-1:0]  pend_vec;
    logic [`CIC_LVL_W-1:0]  pend_lvl;
    logic [`CIC_VEC_W-1:0]  vec;
    logic [`CIC_LVL_W-1:0]  lvl;
    logic                   pm_rd;
    logic [`CIC_ADDR_W-1:0] pm_addr;
    logic                   svc_entry;
    logic [`CIC_ADDR_W-1:0] svc_addr;
    logic [`CIC_LVL_W-1:0]  svc_level;
    logic                   ret_done;
    cic_trap_s              traps;
    logic [`CIC_WORD_W-1:0] rd_data;
  } cic_core_st_s;

  // Request numbers with no source behind them; unknown numbers above the table count as implemented.
  function automatic bit cic_is_reserved(input int n);
    return n inside {5, 18, [21:22], 25, [27:34], [37:39], [42:44], [46:47], [50:60], [62:63], [65:66],
                     77, 81, [86:89], [112:114], [127:128], [142:145], [147:148], 151, [154:156],
                     [158:167], [181:188]};
  endfunction

  function automatic logic [`CIC_ADDR_W-1:0] cic_vec_addr(input logic [`CIC_VEC_W-1:0] vec);
    return `CIC_TABLE_BASE + {{(`CIC_ADDR_W-`CIC_VEC_W-1){1'b0}}, vec, 1'b0};
  endfunction

endpackage

/* File: hw/cic_irq_slot.sv */
// Flag, enable and priority storage for one interrupt request line.
`timescale 1ns/1ps
`include "cic_defs.svh"
module cic_irq_slot
  import cic_pkg::*;
#(
  parameter bit RESERVED = 1'b0
) (
  input  wire logic                   clk_sys,
  input  wire logic                   rst,
  input  wire logic                   src_set,
  input  wire logic                   wr_flag,
  input  wire logic                   wr_enable,
  input  wire logic                   wr_prio,
  input  wire logic                   wr_bit,
  input  wire logic [`CIC_PRIO_W-1:0] wr_prio_val,
  output cic_slot_s                   slot,
  output logic                        req
);

  generate
    if (RESERVED) begin : g_none
      assign slot = '0; // [RQ17]
      assign req  = 1'b0; // [RQ17]
    end else begin : g_store
      cic_slot_s st_r;
      cic_slot_s st_nxt;

      // A peripheral event in the same cycle as a software clear still leaves the flag set.
      always_comb begin
        st_nxt = st_r;
        if (wr_enable) begin
          st_nxt.enable = wr_bit; // [RQ15]
        end
        if (wr_prio) begin
          st_nxt.prio = wr_prio_val; // [RQ15]
        end
        if (wr_flag) begin
          st_nxt.flag = wr_bit; // [RQ15]
        end
        if (src_set) begin
          st_nxt.flag = 1'b1;
        end
      end

      always_ff @(posedge clk_sys) begin
        if (rst) begin
          st_r <= '0;
        end else begin
          st_r <= st_nxt;
        end
      end

      assign slot = st_r;
      assign req  = st_r.flag && st_r.enable && (st_r.prio != '0); // [RQ2]

      chk_set_wins: assert property (@(posedge clk_sys) disable iff (rst) src_set |=> st_r.flag) // [RQ1]
        else $error("Request event lost against a software clear.");
      chk_prio_mute: assert property (@(posedge clk_sys) disable iff (rst) (st_r.prio == '0) |-> !req) // [RQ2]
        else $error("Source at level zero raised a request.");
    end
  endgenerate

endmodule

/* File: hw/cic_core.sv */
// Interrupt and trap arbiter for the secondary core, with vector fetch and service sequencing.
`timescale 1ns/1ps
`include "cic_defs.svh"

// Summary of operation
// [RQ1] Merge all requests into one CPU request.
// [RQ2] Seven user levels; zero mutes, higher pre-empts.
// [RQ3] Equal level: lower vector wins.
// [RQ4] Fixed entry and return latencies.
// [RQ5] Table at 000004h, 24-bit routine addresses fetched.
// [RQ6] Six traps, up to 246 sources.
// [RQ7] Primary table only, no alternate.
// [RQ8] Reset clears state, program counter zero.
// [RQ9] Trap vectors 0-7 with fixed levels.
// [RQ10] Hard trap: vector 2, level 13, two sources.
// [RQ11] Arithmetic trap: vector 4, level 11, six flags.
// [RQ12] Overflow enables separate; catastrophic group shares one.
// [RQ13] Soft trap: vector 6, level 9, no enables.
// [RQ14] Request n uses vector n+8.
// [RQ15] Flag/enable at n/16, priority at n/4.
// [RQ16] Single-bit memory error is request 13.
// [RQ17] Reserved requests store nothing, read zero.
module cic_core
  import cic_pkg::*;
#(
  parameter int NUM_IRQ = `CIC_NUM_IRQ
) (
  input  wire logic                   clk_sys,
  input  wire logic                   rst,
  input  wire logic [NUM_IRQ-1:0]     irq_src,
  input  wire cic_trap_s              trap_evt,
  input  wire cic_trap_s              trap_clr,
  input  wire cic_trap_en_s           trap_en,
  output cic_trap_s                   trap_flags,
  input  wire cic_wr_s                sw_wr,
  input  wire cic_rd_s                sw_rd,
  output logic [`CIC_WORD_W-1:0]      sw_rd_data,
  input  wire logic [`CIC_LVL_W-1:0]  cpu_level,
  output logic                        cpu_irq,
  output logic [`CIC_VEC_W-1:0]       cpu_vector,
  output logic [`CIC_LVL_W-1:0]       cpu_req_level,
  input  wire logic                   cpu_accept,
  input  wire logic                   cpu_return,
  output logic                        pm_rd,
  output logic [`CIC_ADDR_W-1:0]      pm_addr,
  input  wire logic [`CIC_ADDR_W-1:0] pm_data,
  output logic                        svc_entry,
  output logic [`CIC_ADDR_W-1:0]      svc_addr,
  output logic [`CIC_LVL_W-1:0]       svc_level,
  output logic                        ret_done
);

  localparam cic_core_st_s RESET_ST = '{
    state:     ST_IDLE,
    svc_addr:  `CIC_RESET_PC,
    default:   '0
  };

  cic_core_st_s              st_r;
  cic_core_st_s              st_nxt;
  cic_slot_s                 slot_q [NUM_IRQ];
  logic [NUM_IRQ-1:0]        slot_req;
  logic                      hard_req;
  logic                      math_req;
  logic                      soft_req;
  logic                      trap_any;
  logic                      win_found;
  logic [`CIC_VEC_W-1:0]     win_vec;
  logic [`CIC_LVL_W-1:0]     win_lvl;
  logic [`CIC_WORD_W-1:0]    rd_word;
  logic                      accept_now;

  // Storage only exists for request numbers that have a source behind them.
  generate
    for (genvar n = 0; n < NUM_IRQ; n++) begin : g_slot
      localparam logic [`CIC_IDX_W-1:0] FREG = `CIC_IDX_W'(n / `CIC_FLAGS_PER_REG);
      localparam int                    FBIT = n % `CIC_FLAGS_PER_REG;
      localparam logic [`CIC_IDX_W-1:0] PREG = `CIC_IDX_W'(n / `CIC_PRIO_PER_REG);
      localparam int                    PSH  = `CIC_PRIO_STRIDE * (n % `CIC_PRIO_PER_REG);

      cic_irq_slot #(
        .RESERVED (cic_is_reserved(n))
      ) u_slot (
        .clk_sys     (clk_sys),
        .rst         (rst),
        .src_set     (irq_src[n]),
        .wr_flag     (sw_wr.valid && (sw_wr.kind == CIC_KIND_FLAG) && (sw_wr.index == FREG)), // [RQ15]
        .wr_enable   (sw_wr.valid && (sw_wr.kind == CIC_KIND_ENABLE) && (sw_wr.index == FREG)), // [RQ15]
        .wr_prio     (sw_wr.valid && (sw_wr.kind == CIC_KIND_PRIO) && (sw_wr.index == PREG)), // [RQ15]
        .wr_bit      (sw_wr.data[FBIT]),
        .wr_prio_val (sw_wr.data[PSH +: `CIC_PRIO_W]),
        .slot        (slot_q[n]),
        .req         (slot_req[n])
      );
    end
  endgenerate

  // Trap groups: each flag is kept, only the trap request is gated.
  always_comb begin
    hard_req = st_r.traps.double_bit_mem_error
             | (st_r.traps.software_hard_trap & trap_en.software_hard_trap_en); // [RQ10]
    math_req = (st_r.traps.acc_a_overflow & trap_en.acc_a_ovf_en)
             | (st_r.traps.acc_b_overflow & trap_en.acc_b_ovf_en)
             | ((st_r.traps.acc_a_catastrophic | st_r.traps.acc_b_catastrophic
                 | st_r.traps.shift_acc_error | st_r.traps.divide_by_zero)
                & trap_en.catastrophic_en); // [RQ11] [RQ12]
    soft_req = st_r.traps.bus_error_one | st_r.traps.no_address_error
             | st_r.traps.data_address_error | st_r.traps.bus_error_two
             | st_r.traps.loop_nesting_overflow | st_r.traps.auxiliary_pll_unlock; // [RQ13]
    trap_any = st_r.traps.osc_fail | st_r.traps.address_error | hard_req
             | st_r.traps.stack_error | math_req | soft_req;
  end

  // Traps rank by vector, which matches their levels, and all sit above any user level.
  always_comb begin
    win_found = 1'b0;
    win_vec   = '0;
    win_lvl   = '0;
    if (st_r.traps.osc_fail) begin
      win_found = 1'b1; // [RQ9]
      win_vec   = `CIC_VEC_OSC;
      win_lvl   = `CIC_LVL_OSC;
    end else if (st_r.traps.address_error) begin
      win_found = 1'b1; // [RQ9]
      win_vec   = `CIC_VEC_ADDR;
      win_lvl   = `CIC_LVL_ADDR;
    end else if (hard_req) begin
      win_found = 1'b1; // [RQ10]
      win_vec   = `CIC_VEC_HARD;
      win_lvl   = `CIC_LVL_HARD;
    end else if (st_r.traps.stack_error) begin
      win_found = 1'b1; // [RQ9]
      win_vec   = `CIC_VEC_STACK;
      win_lvl   = `CIC_LVL_STACK;
    end else if (math_req) begin
      win_found = 1'b1; // [RQ11]
      win_vec   = `CIC_VEC_MATH;
      win_lvl   = `CIC_LVL_MATH;
    end else if (soft_req) begin
      win_found = 1'b1; // [RQ13]
      win_vec   = `CIC_VEC_SOFT;
      win_lvl   = `CIC_LVL_SOFT;
    end
    // Strictly greater keeps the lowest vector on a tie; the scan is long but purely combinational.
    for (int n = 0; n < NUM_IRQ; n++) begin
      if (slot_req[n] && ({1'b0, slot_q[n].prio} > win_lvl)) begin
        win_found = 1'b1; // [RQ2] [RQ3] [RQ6]
        win_vec   = `CIC_VEC_W'(n) + `CIC_IRQ_VEC_OFS; // [RQ14] [RQ16]
        win_lvl   = {1'b0, slot_q[n].prio};
      end
    end
  end

  // Register view: flag and enable words hold sixteen requests, priority words hold four.
  always_comb begin
    rd_word = '0;
    case (sw_rd.kind)
      CIC_KIND_FLAG, CIC_KIND_ENABLE: begin
        for (int b = 0; b < `CIC_FLAGS_PER_REG; b++) begin
          if (int'(sw_rd.index) * `CIC_FLAGS_PER_REG + b < NUM_IRQ) begin
            rd_word[b] = (sw_rd.kind == CIC_KIND_FLAG)
                       ? slot_q[int'(sw_rd.index) * `CIC_FLAGS_PER_REG + b].flag
                       : slot_q[int'(sw_rd.index) * `CIC_FLAGS_PER_REG + b].enable; // [RQ15] [RQ17]
          end
        end
      end
      CIC_KIND_PRIO: begin
        for (int j = 0; j < `CIC_PRIO_PER_REG; j++) begin
          if (int'(sw_rd.index) * `CIC_PRIO_PER_REG + j < NUM_IRQ) begin
            rd_word[j * `CIC_PRIO_STRIDE +: `CIC_PRIO_W] =
              slot_q[int'(sw_rd.index) * `CIC_PRIO_PER_REG + j].prio; // [RQ15] [RQ17]
          end
        end
      end
      default: begin
        rd_word = '0;
      end
    endcase
  end

  assign accept_now = cpu_irq && cpu_accept;

  always_comb begin
    st_nxt           = st_r;
    st_nxt.pm_rd     = 1'b0;
    st_nxt.svc_entry = 1'b0;
    st_nxt.ret_done  = 1'b0;
    st_nxt.pend      = win_found;
    st_nxt.pend_vec  = win_vec;
    st_nxt.pend_lvl  = win_lvl;
    st_nxt.rd_data   = rd_word;
    // A trap event in the clearing cycle keeps its flag.
    st_nxt.traps     = cic_trap_s'((st_r.traps & ~trap_clr) | trap_evt);
    case (st_r.state)
      ST_IDLE: begin
        if (accept_now) begin
          st_nxt.vec     = st_r.pend_vec;
          st_nxt.lvl     = st_r.pend_lvl;
          st_nxt.pm_addr = cic_vec_addr(st_r.pend_vec); // [RQ5] [RQ7] [RQ14]
          st_nxt.pm_rd   = 1'b1;
          st_nxt.state   = ST_FETCH; // [RQ4]
        end else if (cpu_return) begin
          st_nxt.cnt     = `CIC_RET_PRELOAD; // [RQ4]
          st_nxt.state   = ST_RET;
        end
      end
      ST_FETCH: begin
        st_nxt.state = ST_WAIT;
      end
      ST_WAIT: begin
        st_nxt.svc_addr  = pm_data; // [RQ5]
        st_nxt.svc_level = st_r.lvl;
        st_nxt.svc_entry = 1'b1;
        st_nxt.state     = ST_ENTRY;
      end
      ST_ENTRY: begin
        st_nxt.state = ST_IDLE;
      end
      ST_RET: begin
        if (st_r.cnt == '0) begin
          st_nxt.ret_done = 1'b1; // [RQ4]
          st_nxt.state    = ST_IDLE;
        end else begin
          st_nxt.cnt = st_r.cnt - `CIC_CNT_W'(1);
        end
      end
      default: begin
        st_nxt.state = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      st_r <= RESET_ST; // [RQ8]
    end else begin
      st_r <= st_nxt;
    end
  end

  // Only one request leaves the block, and only while no dispatch or return is in flight.
  assign cpu_irq       = (st_r.state == ST_IDLE) && st_r.pend && (st_r.pend_lvl > cpu_level); // [RQ1] [RQ2]
  assign cpu_vector    = st_r.pend_vec;
  assign cpu_req_level = st_r.pend_lvl;
  assign pm_rd         = st_r.pm_rd;
  assign pm_addr       = st_r.pm_addr;
  assign svc_entry     = st_r.svc_entry;
  assign svc_addr      = st_r.svc_addr;
  assign svc_level     = st_r.svc_level;
  assign ret_done      = st_r.ret_done;
  assign trap_flags    = st_r.traps;
  assign sw_rd_data    = st_r.rd_data;

  default clocking cb_sys @(posedge clk_sys);
  endclocking
  default disable iff (rst);

  sequence s_accept;
    (st_r.state == ST_IDLE) && cpu_irq && cpu_accept;
  endsequence

  sequence s_fetch;
    pm_rd && (st_r.state == ST_FETCH);
  endsequence

  sequence s_ret_start;
    (st_r.state == ST_IDLE) && !(cpu_irq && cpu_accept) && cpu_return;
  endsequence

  property p_entry_fixed;
    s_accept |=> s_fetch ##1 !svc_entry ##1 svc_entry;
  endproperty

  property p_ret_fixed;
    s_ret_start |=> !ret_done [*2] ##1 ret_done;
  endproperty

  chk_entry_fixed: assert property (p_entry_fixed) // [RQ4]
    else $error("Service entry did not follow accept by three cycles.");
  chk_ret_fixed: assert property (p_ret_fixed) // [RQ4]
    else $error("Return did not complete in three cycles.");
  chk_fetch_addr: assert property (s_fetch |-> (pm_addr == cic_vec_addr(st_r.vec))
                                   && (st_r.vec == $past(cpu_vector, 1))) // [RQ14]
    else $error("Table fetch address does not match the accepted vector.");
  chk_primary_only: assert property (pm_rd |-> (pm_addr >= `CIC_TABLE_BASE)
                                     && (pm_addr < `CIC_TABLE_BASE + `CIC_TABLE_SPAN)) // [RQ7]
    else $error("Fetch left the primary vector table.");
  chk_entry_addr: assert property ((st_r.state == ST_WAIT) |=> svc_entry
                                   && (svc_addr == $past(pm_data, 1))) // [RQ5]
    else $error("Routine address was not taken from the table word.");
  chk_single_req: assert property (cpu_irq |-> (cpu_req_level > cpu_level)
                                   && (cpu_req_level != '0)) // [RQ2]
    else $error("Request raised without outranking the CPU level.");
  chk_osc_wins: assert property (st_r.traps.osc_fail |=> st_r.pend && (cpu_vector == `CIC_VEC_OSC)
                                 && (cpu_req_level == `CIC_LVL_OSC)) // [RQ9]
    else $error("Oscillator failure did not take the top slot.");
  chk_hard_trap: assert property (st_r.traps.double_bit_mem_error && !st_r.traps.osc_fail
                                  && !st_r.traps.address_error
                                  |=> (cpu_vector == `CIC_VEC_HARD) && (cpu_req_level == `CIC_LVL_HARD)) // [RQ10]
    else $error("Double-bit memory error did not raise the hard trap.");
  chk_math_gate: assert property (!math_req |=> !(st_r.pend && (cpu_vector == `CIC_VEC_MATH))) // [RQ12]
    else $error("Arithmetic trap raised with its sources disabled.");
  chk_tie_lower: assert property (!trap_any && slot_req[0] && (slot_q[0].prio == `CIC_PRIO_W'(7))
                                  |=> (cpu_vector == `CIC_IRQ_VEC_OFS)) // [RQ3]
    else $error("Lowest vector lost a tie at the top user level.");
  chk_reset_clear: assert property ($past(rst, 1) |-> (svc_addr == `CIC_RESET_PC) && !svc_entry
                                    && !pm_rd && (trap_flags == '0)) // [RQ8]
    else $error("State not cleared by reset.");

  // The CPU never sees a request while an entry or a return is under way.
  chk_busy_quiet: assert property ((st_r.state != ST_IDLE) |-> !cpu_irq) // [RQ1]
    else $error("Request raised during a dispatch or return.");
  chk_no_accept: assert property ((st_r.state == ST_IDLE) && cpu_accept && !cpu_irq && !cpu_return
                                  |=> (st_r.state == ST_IDLE)) // [RQ1]
    else $error("Accept without a request started a dispatch.");
  chk_fetch_pulse: assert property (pm_rd |=> !pm_rd) // [RQ4]
    else $error("Table read strobe stood too long.");
  chk_entry_level: assert property (s_accept |-> ##3 (svc_level == $past(cpu_req_level, 3))) // [RQ2]
    else $error("Entered level differs from the accepted one.");
  // Traps sit above every user level, so a low level means a user vector.
  chk_user_vector: assert property (st_r.pend && (st_r.pend_lvl <= `CIC_LVL_USER_MAX)
                                    |-> (st_r.pend_vec >= `CIC_IRQ_VEC_OFS)) // [RQ14]
    else $error("User level request carries a trap vector.");

  // A lower trap wins only while every higher trap is quiet.
  sequence s_math_wins;
    math_req && !hard_req && !st_r.traps.osc_fail && !st_r.traps.address_error && !st_r.traps.stack_error;
  endsequence

  sequence s_soft_wins;
    soft_req && !math_req && !hard_req && !st_r.traps.osc_fail && !st_r.traps.address_error
    && !st_r.traps.stack_error;
  endsequence

  chk_math_trap: assert property (s_math_wins |=> (cpu_vector == `CIC_VEC_MATH)) // [RQ11]
    else $error("Arithmetic trap lost to a lower source.");
  chk_soft_trap: assert property (s_soft_wins |=> (cpu_req_level == `CIC_LVL_SOFT)) // [RQ13]
    else $error("Soft trap lost to a user request.");

endmodule

/* File: bench/cic_pm_model.sv */
// Program memory model that answers a vector fetch one cycle after the read strobe.
`timescale 1ns/1ps
`include "cic_defs.svh"
module cic_pm_model
  import cic_pkg::*;
(
  input  wire logic                   clk_sys,
  input  wire logic                   pm_rd,
  input  wire logic [`CIC_ADDR_W-1:0] pm_addr,
  output logic      [`CIC_ADDR_W-1:0] pm_data
);
  // Outside its one valid cycle the bus flips every cycle, so a late or early sample shows up as a bad address.
  initial pm_data = 24'h00_0000;
  always @(posedge clk_sys) begin
    if (pm_rd) begin
      pm_data <= {8'h3c, pm_addr[15:0]};
    end else begin
      pm_data <= ~pm_data;
    end
  end
endmodule

/* File: bench/cic_core_tb.sv */
// Self-checking testbench of the core interrupt controller.
`timescale 1ns/1ps
`include "cic_defs.svh"
module cic_core_tb;
  import cic_pkg::*;
  localparam int NIRQ = 16;
  logic                   clk_sys;
  logic                   rst;
  logic [NIRQ-1:0]        irq_src;
  cic_trap_s              trap_evt;
  cic_trap_s              trap_clr;
  cic_trap_en_s           trap_en;
  cic_trap_s              trap_flags;
  cic_wr_s                sw_wr;
  cic_rd_s                sw_rd;
  logic [15:0]            sw_rd_data;
  logic [3:0]             cpu_level;
  logic                   cpu_irq;
  logic [7:0]             cpu_vector;
  logic [3:0]             cpu_req_level;
  logic                   cpu_accept;
  logic                   cpu_return;
  logic                   pm_rd;
  logic [23:0]            pm_addr;
  logic [23:0]            pm_data;
  logic                   svc_entry;
  logic [23:0]            svc_addr;
  logic [3:0]             svc_level;
  logic                   ret_done;
  int                     err_total;
  int                     comparisons;

  cic_core #(.NUM_IRQ(NIRQ)) i_cic_core (.clk_sys(clk_sys), .rst(rst), .irq_src(irq_src), .trap_evt(trap_evt),
    .trap_clr(trap_clr), .trap_en(trap_en), .trap_flags(trap_flags), .sw_wr(sw_wr), .sw_rd(sw_rd),
    .sw_rd_data(sw_rd_data), .cpu_level(cpu_level), .cpu_irq(cpu_irq), .cpu_vector(cpu_vector),
    .cpu_req_level(cpu_req_level), .cpu_accept(cpu_accept), .cpu_return(cpu_return), .pm_rd(pm_rd),
    .pm_addr(pm_addr), .pm_data(pm_data), .svc_entry(svc_entry), .svc_addr(svc_addr), .svc_level(svc_level),
    .ret_done(ret_done));

  cic_pm_model i_cic_pm_model (.clk_sys(clk_sys), .pm_rd(pm_rd), .pm_addr(pm_addr), .pm_data(pm_data));

  initial begin
    clk_sys = 1'b0;
    forever #25 clk_sys = ~clk_sys;
  end

  task automatic tick(input int n = 1);
    repeat (n) @(posedge clk_sys);
    #5;
  endtask

  task automatic chk(input string what, input logic [23:0] seen, input logic [23:0] exp);
    comparisons++;
    if (seen !== exp) begin
      err_total++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic stop_test();
    $display("Comparisons %0d, mismatches %0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  task automatic wr(input cic_kind_e k, input int idx, input logic [15:0] d);
    sw_wr = '{1'b1, k, 6'(idx), d};
    tick();
    sw_wr.valid = 1'b0;
  endtask

  task automatic rd_chk(input cic_kind_e k, input int idx, input logic [15:0] exp, input string what);
    sw_rd = '{k, 6'(idx)};
    tick(2);
    chk(what, 24'(sw_rd_data), 24'(exp));
  endtask

  // Traps are ordered MSB first in the struct, so the bit index picks vector and level.
  function automatic logic [7:0] tvec(input int b);
    return (b == 16) ? 8'h00 : (b == 15) ? 8'h01 : (b == 14) ? 8'h03 : (b >= 12) ? 8'h02 : (b >= 6) ? 8'h04 : 8'h06;
  endfunction

  function automatic logic [3:0] tlvl(input int b);
    return (b == 16) ? 4'hf : (b == 15) ? 4'he : (b == 14) ? 4'hc : (b >= 12) ? 4'hd : (b >= 6) ? 4'hb : 4'h9;
  endfunction

  task automatic dispatch(input logic [7:0] vec, input logic [3:0] lvl);
    logic [23:0] ta;
    ta = 24'h00_0004 + {15'h0000, vec, 1'b0};
    chk("cpu_irq", 24'(cpu_irq), 24'h1);
    chk("cpu_vector", 24'(cpu_vector), 24'(vec));
    chk("cpu_req_level", 24'(cpu_req_level), 24'(lvl));
    cpu_accept = 1'b1;
    tick();
    cpu_accept = 1'b0;
    chk("pm_rd", 24'(pm_rd), 24'h1);
    chk("pm_addr", pm_addr, ta);
    chk("cpu_irq", 24'(cpu_irq), 24'h0);
    tick(2);
    chk("svc_entry", 24'(svc_entry), 24'h1);
    chk("svc_addr", svc_addr, {8'h3c, ta[15:0]});
    chk("svc_level", 24'(svc_level), 24'(lvl));
    tick();
    chk("svc_entry", 24'(svc_entry), 24'h0);
  endtask

  task automatic reset_chk();
    rst = 1'b1;
    tick(6);
    rst = 1'b0;
    tick();
    chk("cpu_irq", 24'(cpu_irq), 24'h0);
    chk("svc_addr", svc_addr, 24'h00_0000);
    chk("trap_flags", 24'(trap_flags), 24'h0);
  endtask

  task automatic t_regs();
    wr(CIC_KIND_ENABLE, 0, 16'hffff);
    rd_chk(CIC_KIND_ENABLE, 0, 16'hffdf, "enable_reg_0");
    wr(CIC_KIND_PRIO, 1, 16'hffff);
    rd_chk(CIC_KIND_PRIO, 1, 16'h7707, "prio_reg_1");
    irq_src[5] = 1'b1;
    tick();
    irq_src = '0;
    tick(2);
    chk("cpu_irq", 24'(cpu_irq), 24'h0);
    rd_chk(CIC_KIND_FLAG, 0, 16'h0000, "flag_reg_0");
  endtask

  task automatic t_user();
    wr(CIC_KIND_PRIO, 1, 16'h0300);
    wr(CIC_KIND_PRIO, 3, 16'h0030);
    irq_src[6] = 1'b1;
    irq_src[13] = 1'b1;
    tick();
    irq_src = '0;
    tick(2);
    chk("cpu_vector", 24'(cpu_vector), 24'h00_000e);
    rd_chk(CIC_KIND_FLAG, 0, 16'h2040, "flag_reg_0");
    wr(CIC_KIND_PRIO, 3, 16'h0050);
    tick(2);
    chk("cpu_vector", 24'(cpu_vector), 24'h00_0015);
    cpu_level = 4'h5;
    tick();
    chk("cpu_irq", 24'(cpu_irq), 24'h0);
    cpu_level = 4'h4;
    tick();
    dispatch(8'h15, 4'h5);
    wr(CIC_KIND_PRIO, 3, 16'h0000);
    cpu_level = 4'h0;
    tick(2);
    dispatch(8'h0e, 4'h3);
    cpu_return = 1'b1;
    tick();
    cpu_return = 1'b0;
    for (int i = 1; i <= 4; i++) begin
      chk("ret_done", 24'(ret_done), 24'(i == 3));
      tick();
    end
    wr(CIC_KIND_PRIO, 0, 16'h0007);
    wr(CIC_KIND_PRIO, 1, 16'h0700);
    irq_src[0] = 1'b1;
    tick();
    irq_src = '0;
    tick(2);
    chk("cpu_vector", 24'(cpu_vector), 24'h00_0008);
    wr(CIC_KIND_FLAG, 0, 16'h0000);
  endtask

  // A level-7 user request stays pending throughout, so every trap must outrank it.
  task automatic t_traps();
    wr(CIC_KIND_PRIO, 1, 16'h0700);
    irq_src[6] = 1'b1;
    trap_en = 4'hf;
    for (int b = 16; b >= 0; b--) begin
      trap_evt = cic_trap_s'(17'h1 << b);
      tick();
      irq_src = '0;
      trap_evt = '0;
      tick(2);
      chk("trap_flags", 24'(trap_flags), 24'(17'h1 << b));
      chk("cpu_vector", 24'(cpu_vector), 24'(tvec(b)));
      chk("cpu_req_level", 24'(cpu_req_level), 24'(tlvl(b)));
      if (b == 16) begin
        dispatch(8'h00, 4'hf);
      end
      trap_clr = cic_trap_s'(17'h1 << b);
      tick();
      trap_clr = '0;
      tick(2);
    end
    trap_en = 4'h0;
    trap_evt = cic_trap_s'(17'h1fc0);
    tick();
    trap_evt = '0;
    tick(2);
    chk("trap_flags", 24'(trap_flags), 24'h00_1fc0);
    chk("cpu_vector", 24'(cpu_vector), 24'h00_000e);
    trap_en = 4'h1;
    tick(2);
    chk("cpu_vector", 24'(cpu_vector), 24'h00_0004);
    trap_clr = cic_trap_s'(17'h03c0);
    tick();
    trap_clr = '0;
    tick(2);
    chk("cpu_vector", 24'(cpu_vector), 24'h00_000e);
    trap_en = 4'h2;
    tick(2);
    chk("cpu_vector", 24'(cpu_vector), 24'h00_0004);
    trap_en = 4'h8;
    trap_clr = cic_trap_s'(17'h0c00);
    tick();
    trap_clr = '0;
    tick(2);
    chk("cpu_vector", 24'(cpu_vector), 24'h00_0002);
    trap_evt = '1;
    tick();
    trap_evt = '0;
  endtask

  initial begin
    err_total = 0;
    comparisons = 0;
    rst = 1'b1;
    irq_src = '0;
    trap_evt = '0;
    trap_clr = '0;
    trap_en = '0;
    sw_wr = '0;
    sw_rd = '0;
    cpu_level = 4'h0;
    cpu_accept = 1'b0;
    cpu_return = 1'b0;
    reset_chk();
    t_regs();
    t_user();
    t_traps();
    reset_chk();
    stop_test();
  end

  // The sequence needs well under a thousand cycles; four thousand means a hang.
  initial begin
    #(50 * 4000);
    err_total++;
    stop_test();
  end
endmodule
